// file: hw/pcsf_defines.svh
// Constants of the phase current and speed feedback block.
// Assumes inclusion by bare name from the package and every module.
`ifndef PCSF_DEFINES_SVH
`define PCSF_DEFINES_SVH
// Timing: clock period and sample period in ns, and the derived cycle count.
`define PCSF_CLK_NS      40
`define PCSF_SAMPLE_NS   100000
`define PCSF_SAMPLE_CYC  (`PCSF_SAMPLE_NS / `PCSF_CLK_NS)
// Converter start word and result word layout.
`define PCSF_START_WORD  16'h1801
`define PCSF_RES_LSB     6
`define PCSF_RES_MSB     15
`define PCSF_MID_SCALE   16'h0200
`define PCSF_MID_WORD    16'h8000
// Full-scale result word, and the currents that both range ends give with the reset constant.
`define PCSF_FULL_WORD   16'hFFC0
`define PCSF_FULL_CUR    16'h26F2
`define PCSF_ZERO_CUR    16'hD8FA
`define PCSF_FRAC_SHIFT  8
// Reset values of the software visible constants.
`define PCSF_KCUR_RST    16'h1383
`define PCSF_KSPD_RST    16'h0DA7
`define PCSF_IA_OFS_RST  16'h0070
`define PCSF_PERIOD_RST  8'h1E
// Register byte addresses.
`define PCSF_REG_CTRL    8'h00
`define PCSF_REG_STAT    8'h04
`define PCSF_REG_IA      8'h08
`define PCSF_REG_IB      8'h0C
`define PCSF_REG_SPEED   8'h10
`define PCSF_REG_PULSES  8'h14
`define PCSF_REG_PERIOD  8'h18
`define PCSF_REG_KCUR    8'h1C
`define PCSF_REG_KSPD    8'h20
`define PCSF_REG_IA_OFS  8'h24
`define PCSF_REG_SAMPLES 8'h28
`define PCSF_REG_RAW_A   8'h2C
// Bit positions inside the control and status registers.
`define PCSF_CTRL_RUN    0
`define PCSF_STAT_ACTIVE 0
`define PCSF_STAT_RUN    1
`endif

// file: hw/pcsf_pkg.sv
// Types and shared arithmetic of the phase current and speed feedback block.
// Assumes the defines header is on the include path.
`include "pcsf_defines.svh"
package pcsf_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    PCSF_IDLE   = 5'b00001,
    PCSF_START  = 5'b00010,
    PCSF_SETTLE = 5'b00100,
    PCSF_POLL   = 5'b01000,
    PCSF_CALC   = 5'b10000
  } pcsf_state_e;

  // Whole state of the sequencer and register file.
  typedef struct packed {
    pcsf_state_e state;
    logic [15:0] tmr;
    logic [15:0] ctrl_word;
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] speed;
    logic [15:0] encincr;
    logic [15:0] speedtmp;
    logic [7:0]  speedstep;
    logic [15:0] raw_a;
    logic [15:0] samples;
    logic        valid;
    logic        run;
    logic [15:0] kcur;
    logic [15:0] kspd;
    logic [15:0] ia_ofs;
    logic [7:0]  period;
    logic [31:0] prdata;
  } pcsf_core_s;

  // Whole state of the quadrature decoder.
  typedef struct packed {
    logic [1:0]  meta;
    logic [1:0]  sync;
    logic [1:0]  prev;
    logic [15:0] count;
  } pcsf_quad_s;

  // Multiplies a signed value by an 8.8 constant, keeps the low word after the shift.
  function automatic logic [15:0] pcsf_scale88(input logic [15:0] v, input logic [15:0] k);
    logic signed [31:0] p;
    p = $signed(v) * $signed(k);
    return p[`PCSF_FRAC_SHIFT+15:`PCSF_FRAC_SHIFT];
  endfunction : pcsf_scale88
endpackage : pcsf_pkg

// file: hw/pcsf_quad.sv
// Quadrature decoder with the pulse count register, counting every single-channel edge; edges on both channels in one cycle are not counted.
// Assumes asynchronous encoder pins and a same-clock read-and-clear strobe.
`include "pcsf_defines.svh"
module pcsf_quad
  import pcsf_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Encoder channel pins.
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  // Read-and-clear port of the pulse count register.
  input  wire logic        clr,
  output logic      [15:0] pulse_count_register
);
  pcsf_quad_s q;
  pcsf_quad_s n;

  // Two flip-flop synchroniser, then one edge on either channel steps the count.
  always_comb
  begin
    n      = q;
    n.meta = {enc_a, enc_b};
    n.sync = q.meta;
    n.prev = q.sync;
    // A count that arrives with the clear is kept, not lost.
    n.count = clr ? 16'h0000 : q.count;
    if ((q.sync ^ q.prev) == 2'b01 || (q.sync ^ q.prev) == 2'b10)
    begin
      if (q.prev[1] ^ q.sync[0])
        n.count = n.count + 16'h0001;
      else
        n.count = n.count - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= n;
  end

  assign pulse_count_register = q.count;

  a_quad_step:
  assert property (@(posedge clk) disable iff (!arst_n)
    (!clr && ((q.sync ^ q.prev) == 2'b01 || (q.sync ^ q.prev) == 2'b10))
      |=> (pulse_count_register != $past(pulse_count_register)))
    else $error("Single channel edge did not step the pulse count.");
endmodule : pcsf_quad

// file: hw/pcsf_cur.sv
// Current conditioning path: result word to a 4.12 per-unit current.
// Assumes a stable result word and constants while its output is sampled.
`include "pcsf_defines.svh"
module pcsf_cur
  import pcsf_pkg::*;
(
  // Raw converter result and scaling constants.
  input  wire logic [15:0] result_word,
  input  wire logic [15:0] kcur,
  input  wire logic [15:0] offset,
  // Scaled current.
  output logic      [15:0] current
);
  logic [15:0] centred;

  // Keep the ten conversion bits at the low end, then remove mid-scale.
  assign centred = {6'h00, result_word[`PCSF_RES_MSB:`PCSF_RES_LSB]} - `PCSF_MID_SCALE;

  // Scale to 4.12 and remove the residual offset; wraps without saturation.
  assign current = pcsf_scale88(centred, kcur) - offset;
endmodule : pcsf_cur

// file: hw/pcsf_top.sv
// Feedback front end of a motor control loop: current and speed sensing.
// Assumes converters and APB master share clk; encoder pins are asynchronous.
//
// The implementer's own choices: the address map and the APB register port.
`include "pcsf_defines.svh"
module pcsf_top
  import pcsf_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `PCSF_SAMPLE_CYC
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Converter control and results.
  output logic             converter_control_wr,
  output logic      [15:0] converter_control_word,
  input  wire logic        converter_busy,
  input  wire logic [15:0] conversion_result_word_a,
  input  wire logic [15:0] conversion_result_word_b,
  // Encoder pins.
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  // Feedback outputs.
  output logic      [15:0] phase_a_current,
  output logic      [15:0] phase_b_current,
  output logic      [15:0] speed,
  output logic             sample_valid
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [15:0] TMR_LOAD = 16'(SAMPLE_CYC - 1);

  localparam pcsf_core_s CORE_RST = '{
    state:     PCSF_IDLE,
    tmr:       TMR_LOAD,
    ctrl_word: 16'h0000,
    ia:        16'h0000,
    ib:        16'h0000,
    speed:     16'h0000,
    encincr:   16'h0000,
    speedtmp:  16'h0000,
    speedstep: `PCSF_PERIOD_RST,
    raw_a:     16'h0000,
    samples:   16'h0000,
    valid:     1'b0,
    run:       1'b0,
    kcur:      `PCSF_KCUR_RST,
    kspd:      `PCSF_KSPD_RST,
    ia_ofs:    `PCSF_IA_OFS_RST,
    period:    `PCSF_PERIOD_RST,
    prdata:    32'h0000_0000
  };

  pcsf_core_s  q;
  pcsf_core_s  n;
  logic        tick;
  logic        cnt_clr;
  logic [15:0] pulse_cnt;
  logic [15:0] cur_a;
  logic [15:0] cur_b;
  logic [15:0] spd_acc;
  logic [31:0] rd;

  // Tells whether a byte address holds a register.
  function automatic logic reg_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `PCSF_REG_RAW_A);
  endfunction : reg_hit

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  // Quadrature decoder and its pulse count register.
  pcsf_quad u_quad (
    .clk                  (clk),
    .arst_n               (arst_n),
    .enc_a                (enc_a),
    .enc_b                (enc_b),
    .clr                  (cnt_clr),
    .pulse_count_register (pulse_cnt)
  );

  // Phase A path, from the phase_a_input channel of the first converter.
  pcsf_cur u_cur_a (
    .result_word (conversion_result_word_a),
    .kcur        (q.kcur),
    .offset      (q.ia_ofs),
    .current     (cur_a)
  );

  // Phase B path, from the phase_b_input channel of the second converter.
  pcsf_cur u_cur_b (
    .result_word (conversion_result_word_b),
    .kcur        (q.kcur),
    .offset      (16'h0000),
    .current     (cur_b)
  );

  // ****************************************************************
  // Sequencer and register file
  // ****************************************************************
  // Next-state logic for the sample timer, conversion sequence and registers.
  always_comb
  begin
    n       = q;
    n.valid = 1'b0;
    cnt_clr = 1'b0;
    spd_acc = q.speedtmp + q.encincr;
    tick    = q.run && (q.tmr == 16'h0000);
    // One tick per sample period while running.
    if (!q.run || tick)
      n.tmr = TMR_LOAD;
    else
      n.tmr = q.tmr - 16'h0001;

    unique case (q.state)
      PCSF_IDLE:
      begin
        if (tick)
        begin
          n.state     = PCSF_START;
          n.ctrl_word = `PCSF_START_WORD;
          n.encincr   = pulse_cnt;
          cnt_clr     = 1'b1;
        end
      end
      PCSF_START:
        n.state = PCSF_SETTLE;
      PCSF_SETTLE:
        n.state = PCSF_POLL;
      PCSF_POLL:
      begin
        if (!converter_busy)
          n.state = PCSF_CALC;
      end
      PCSF_CALC:
      begin
        n.state   = PCSF_IDLE;
        n.valid   = 1'b1;
        n.samples = q.samples + 16'h0001;
        n.raw_a   = conversion_result_word_a;
        n.ia      = cur_a;
        n.ib      = cur_b;
        // The speed counter steps once per sample; speed is skipped until it expires.
        if (q.speedstep > 8'h01)
        begin
          n.speedstep = q.speedstep - 8'h01;
          n.speedtmp  = spd_acc;
        end
        else
        begin
          n.speed     = pcsf_scale88(spd_acc, q.kspd);
          n.speedtmp  = 16'h0000;
          n.speedstep = q.period;
        end
      end
    endcase

    // Register writes take effect in the access phase.
    if (psel && penable && pwrite)
    begin
      unique case (paddr)
        `PCSF_REG_CTRL:   n.run    = pwdata[`PCSF_CTRL_RUN];
        `PCSF_REG_PERIOD: n.period = pwdata[7:0];
        `PCSF_REG_KCUR:   n.kcur   = pwdata[15:0];
        `PCSF_REG_KSPD:   n.kspd   = pwdata[15:0];
        `PCSF_REG_IA_OFS: n.ia_ofs = pwdata[15:0];
        default: ;
      endcase
    end

    // Read data is captured in the setup phase so prdata comes from a flop.
    rd = 32'h0000_0000;
    unique case (paddr)
      `PCSF_REG_CTRL:    rd[`PCSF_CTRL_RUN] = q.run;
      `PCSF_REG_STAT:
      begin
        rd[`PCSF_STAT_ACTIVE] = (q.state != PCSF_IDLE);
        rd[`PCSF_STAT_RUN]    = q.run;
      end
      `PCSF_REG_IA:      rd[15:0] = q.ia;
      `PCSF_REG_IB:      rd[15:0] = q.ib;
      `PCSF_REG_SPEED:   rd[15:0] = q.speed;
      `PCSF_REG_PULSES:  rd[15:0] = q.encincr;
      `PCSF_REG_PERIOD:  rd[7:0]  = q.period;
      `PCSF_REG_KCUR:    rd[15:0] = q.kcur;
      `PCSF_REG_KSPD:    rd[15:0] = q.kspd;
      `PCSF_REG_IA_OFS:  rd[15:0] = q.ia_ofs;
      `PCSF_REG_SAMPLES: rd[15:0] = q.samples;
      `PCSF_REG_RAW_A:   rd[15:0] = q.raw_a;
      default:           rd       = 32'h0000_0000;
    endcase
    if (psel && !penable)
      n.prdata = rd;
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= CORE_RST;
    else
      q <= n;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The slave never inserts wait states; unmapped addresses answer with an error.
  assign pready                 = 1'b1;
  assign pslverr                = psel && penable && !reg_hit(paddr);
  assign prdata                 = q.prdata;
  assign converter_control_wr   = (q.state == PCSF_START);
  assign converter_control_word = q.ctrl_word;
  assign phase_a_current        = q.ia;
  assign phase_b_current        = q.ib;
  assign speed                  = q.speed;
  assign sample_valid           = q.valid;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Cycles since the last start, restarted whenever sampling stops.
  logic [15:0] gap_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      gap_q <= 16'h0000;
    else if (!q.run)
      gap_q <= 16'h0000;
    else if (converter_control_wr)
      gap_q <= 16'h0001;
    else if (gap_q != 16'h0000)
      gap_q <= gap_q + 16'h0001;
  end

  a_start_word:
  assert property (@(posedge clk) disable iff (!arst_n)
    converter_control_wr |-> (converter_control_word == `PCSF_START_WORD) ##1 !converter_control_wr)
    else $error("Converter start is not a single write of the start word.");

  a_poll_wait:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_POLL && converter_busy) |=> (q.state == PCSF_POLL) && !sample_valid)
    else $error("Sequence left polling while the converter was busy.");

  a_poll_exit:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_POLL && !converter_busy) |=> ##1 sample_valid && (q.state == PCSF_IDLE))
    else $error("Results not delivered two cycles after busy cleared.");

  a_sample_gap:
  assert property (@(posedge clk) disable iff (!arst_n)
    (converter_control_wr && gap_q != 16'h0000) |-> (gap_q == 16'(SAMPLE_CYC)))
    else $error("Conversion starts are not one sample period apart.");

  a_ia_mid:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_CALC && conversion_result_word_a == `PCSF_MID_WORD)
      |=> ((phase_a_current + $past(q.ia_ofs)) == 16'h0000))
    else $error("Mid-scale phase A does not read minus the residual offset.");

  a_ib_mid:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_CALC && conversion_result_word_b == `PCSF_MID_WORD)
      |=> (phase_b_current == 16'h0000))
    else $error("Mid-scale phase B does not read zero.");

  a_enc_read:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_IDLE && tick) |-> cnt_clr ##1 (q.encincr == $past(pulse_cnt)))
    else $error("Pulse count not captured and cleared at the sample tick.");

  a_speed_skip:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_CALC && q.speedstep > 8'h01)
      |=> (speed == $past(speed)) && (q.speedstep == $past(q.speedstep) - 8'h01))
    else $error("Speed changed before the speed counter expired.");

  a_speed_reload:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_CALC && q.speedstep <= 8'h01)
      |=> (q.speedtmp == 16'h0000) && (q.speedstep == $past(q.period)))
    else $error("Speed counter not reloaded or pulses not cleared.");

  // No conversion is started while sampling is switched off.
  a_idle_quiet:
  assert property (@(posedge clk) disable iff (!arst_n)
    (!q.run && q.state == PCSF_IDLE) |=> !converter_control_wr)
    else $error("Conversion started while sampling was off.");

  // The pulse count register restarts from zero after each read; a same-cycle edge may step it.
  a_count_clear:
  assert property (@(posedge clk) disable iff (!arst_n)
    cnt_clr |=> (pulse_cnt == 16'h0000) || (pulse_cnt == 16'h0001)
      || (pulse_cnt == 16'hFFFF))
    else $error("Pulse count register not cleared after the sample read.");

  // Full-scale phase A with the reset constant gives the largest positive current.
  a_full_scale:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_CALC && conversion_result_word_a == `PCSF_FULL_WORD
      && q.kcur == `PCSF_KCUR_RST)
      |=> ((phase_a_current + $past(q.ia_ofs)) == `PCSF_FULL_CUR))
    else $error("Full-scale phase A does not scale to the expected current.");

  // Zero input on phase B with the reset constant gives the largest negative current.
  a_zero_scale:
  assert property (@(posedge clk) disable iff (!arst_n)
    (q.state == PCSF_CALC && conversion_result_word_b == 16'h0000
      && q.kcur == `PCSF_KCUR_RST)
      |=> (phase_b_current == `PCSF_ZERO_CUR))
    else $error("Zero-input phase B does not scale to the expected current.");

  // Every stored sample steps the sample counter exactly once.
  a_sample_count:
  assert property (@(posedge clk) disable iff (!arst_n)
    sample_valid |-> (q.samples == $past(q.samples) + 16'h0001))
    else $error("Sample counter did not step with the stored sample.");
endmodule : pcsf_top

// file: testbench/pcsf_far_model.sv
// Behavioural pair of converters on the far side of the feedback block.
// Assumes the start pulse and control word come from the block on clk.
`include "pcsf_defines.svh"
module pcsf_far_model
  import pcsf_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Control from the block.
  input  wire logic        converter_control_wr,
  input  wire logic [15:0] converter_control_word,
  // Bench settings: conversion time and input levels.
  input  wire logic [7:0]  busy_cyc,
  input  wire logic [15:0] level_a,
  input  wire logic [15:0] level_b,
  // Answers to the block.
  output logic             converter_busy,
  output logic      [15:0] conversion_result_word_a,
  output logic      [15:0] conversion_result_word_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Converter state
  // ****************************************
  typedef struct packed {
    logic [7:0]  cnt;
    logic [15:0] res_a;
    logic [15:0] res_b;
  } pcsf_far_s;
  pcsf_far_s st_r;
  pcsf_far_s st_nxt;

  // Only the start word launches both channels together.
  always_comb
  begin
    st_nxt = st_r;
    if (converter_control_wr && converter_control_word == `PCSF_START_WORD)
    begin
      st_nxt.cnt   = busy_cyc;
      st_nxt.res_a = {level_a[15:6], 6'h00};
      st_nxt.res_b = {level_b[15:6], 6'h00};
    end
    else if (st_r.cnt != 8'h00)
    begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  // Registers the model state.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // While converting, the result words show garbage rather than the old value.
  assign converter_busy           = (st_r.cnt != 8'h00);
  assign conversion_result_word_a = converter_busy ? ~st_r.res_a : st_r.res_a;
  assign conversion_result_word_b = converter_busy ? ~st_r.res_b : st_r.res_b;
endmodule : pcsf_far_model

// file: testbench/phase_current_and_speed_feedback_test.sv
// Self-checking bench of the feedback block with an APB master.
// Assumes the converter model and a shortened sample period.
`include "pcsf_defines.svh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module phase_current_and_speed_feedback_test
  import pcsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals
  // ****************************************
  localparam int unsigned SCYC = 60;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        wr, busy, enc_a, enc_b, valid, er;
  logic [15:0] word, rwa, rwb, ia, ib, speed, lva, lvb;
  logic [7:0]  busy_cyc;
  logic [1:0]  enc_st;
  int          fail_count, total_checks, cyc, last;
  logic [7:0]  ra [7] = '{`PCSF_REG_CTRL, `PCSF_REG_PERIOD, `PCSF_REG_KCUR, `PCSF_REG_KSPD,
                          `PCSF_REG_IA_OFS, `PCSF_REG_SPEED, `PCSF_REG_PULSES};
  logic [31:0] rv [7] = '{32'h0, 32'h1E, 32'h1383, 32'h0DA7, 32'h70, 32'h0, 32'h0};

  pcsf_top #(.SAMPLE_CYC(SCYC)) u_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .converter_control_wr(wr),
    .converter_control_word(word), .converter_busy(busy), .conversion_result_word_a(rwa),
    .conversion_result_word_b(rwb), .enc_a(enc_a), .enc_b(enc_b), .phase_a_current(ia),
    .phase_b_current(ib), .speed(speed), .sample_valid(valid));
  pcsf_far_model u_far (.clk(clk), .arst_n(arst_n), .converter_control_wr(wr),
    .converter_control_word(word), .busy_cyc(busy_cyc), .level_a(lva), .level_b(lvb),
    .converter_busy(busy), .conversion_result_word_a(rwa), .conversion_result_word_b(rwb));

  // Clock and cycle counter.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // Expected current: centre the ten bits, scale by 8.8, drop eight bits, remove offset.
  function automatic logic [15:0] exp_cur(input logic [15:0] w, input logic [15:0] ofs);
    logic signed [31:0] p;
    p = ($signed({22'h0, w[15:6]}) - 32'sd512) * 32'sd4995;
    p = p >>> 8;
    return p[15:0] - ofs;
  endfunction : exp_cur

  // Expected speed from an accumulated pulse count.
  function automatic logic [15:0] exp_spd(input int n);
    logic signed [31:0] p;
    p = (n * 32'sd3495) >>> 8;
    return p[15:0];
  endfunction : exp_spd

  // Ends the run with the verdict.
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // One APB transfer: setup, access held until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      print_verdict();
    end
  endtask : apb

  // Waits for the next stored sample.
  task automatic wait_valid();
    int n;
    n = 0;
    @(posedge clk);
    while (valid !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000)
    begin
      fail_count++;
      print_verdict();
    end
  endtask : wait_valid

  // Steps the encoder forward by n edges, alternating channels.
  task automatic enc_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk);
      @(posedge clk);
      enc_st = enc_st + 2'd1;
      enc_a <= enc_st[1];
      enc_b <= enc_st[1] ^ enc_st[0];
    end
  endtask : enc_pulses

  // Main sequence.
  initial
  begin
    {psel, penable, pwrite, enc_a, enc_b, arst_n} = '0;
    {paddr, pwdata, enc_st, fail_count, total_checks, cyc, last} = '0;
    busy_cyc = 8'h03;
    lva      = 16'hFFC0;
    lvb      = 16'h0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0, rd, er);
      `CHECK(rd, rv[i])
    end
    // Write path of the settable constants, each restored before sampling starts.
    for (int i = 1; i < 5; i++)
    begin
      apb(1'b1, ra[i], 32'hFFFF_00A5, rd, er);
      apb(1'b0, ra[i], 32'h0, rd, er);
      `CHECK(rd, 32'h0000_00A5)
      apb(1'b1, ra[i], rv[i], rd, er);
    end
    apb(1'b1, `PCSF_REG_SPEED, 32'hFFFF, rd, er);
    apb(1'b0, `PCSF_REG_SPEED, 32'h0, rd, er);
    `CHECK(rd, 32'h0)
    apb(1'b0, 8'h30, 32'h0, rd, er);
    `CHECK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, `PCSF_REG_CTRL, 32'h1, rd, er);
    for (int i = 1; i <= 60; i++)
    begin
      wait_valid();
      if (i == 5) `CHECK(cyc - last, SCYC)
      last = cyc;
      `CHECK(ia, exp_cur(lva, 16'h0070))
      `CHECK(ib, exp_cur(lvb, 16'h0000))
      if (i == 1) `CHECK(word, 16'h1801)
      if (i == 29) `CHECK(speed, 16'h0000)
      if (i == 30) `CHECK(speed, exp_spd(290))
      if (i == 60) `CHECK(speed, exp_spd(300))
      if (i == 30)
      begin
        lva      <= 16'h8000;
        lvb      <= 16'h8000;
        busy_cyc <= 8'h0C;
      end
      enc_pulses(10);
      if (i == 10)
      begin
        apb(1'b0, `PCSF_REG_PULSES, 32'h0, rd, er);
        `CHECK(rd, 32'd10)
        apb(1'b0, `PCSF_REG_SAMPLES, 32'h0, rd, er);
        `CHECK(rd, 32'd10)
        apb(1'b0, `PCSF_REG_RAW_A, 32'h0, rd, er);
        `CHECK(rd, 32'h0000_FFC0)
        apb(1'b0, `PCSF_REG_IA, 32'h0, rd, er);
        `CHECK(rd, {16'h0000, exp_cur(lva, 16'h0070)})
        apb(1'b0, `PCSF_REG_IB, 32'h0, rd, er);
        `CHECK(rd, {16'h0000, exp_cur(lvb, 16'h0000)})
      end
    end
    print_verdict();
  end
endmodule : phase_current_and_speed_feedback_test
